// *** rsso_unit.sv ***
// execution unit for rotate, subtract, skip, set and swap operations
`timescale 1ns/1ps

// Summary of operation
// - rotate left via carry into work register
// - rotate memory right in place, no flags
// - rotate right into work register, no flags
// - rotate memory right via carry in place
// - rotate right via carry into work
// - carry is inverted borrow after subtract
// - borrow subtract operand into work register
// - borrow subtract result back to memory
// - subtracts update all six arithmetic flags
// - plain subtract ignores carry input
// - decrement memory, skip when zero
// - decrement into work, skip when zero
// - increment memory, skip when zero
// - increment into work, skip when zero
// - skip costs dummy cycle, no flags
// - set byte or bit, no flags
// - skip when selected bit is one
// - byte test rewrites, skips when nonzero
// - nibble exchange in place or to work
module rsso_unit (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               op_valid,
  input  wire rsso_pkg::rsso_op_t op_code,
  input  wire logic [7:0]         mem_data,
  input  wire logic [7:0]         imm_data,
  input  wire logic               use_imm,
  input  wire logic [2:0]         bit_sel,
  output logic                    op_ready,
  output logic [7:0]              work_reg,
  output logic                    mem_we,
  output logic [7:0]              mem_wdata,
  output logic                    skip_taken,
  output logic                    dummy_cycle,
  output logic                    carry_flag,
  output logic                    half_byte_carry_flag,
  output logic                    zero_flag,
  output logic                    signed_range_flag,
  output logic                    signed_result_flag,
  output logic                    chained_zero_flag
);
  import rsso_pkg::*;

  rsso_state_t state;
  rsso_state_t next_state;
  logic [7:0]  next_work_reg;
  logic        next_mem_we;
  logic [7:0]  next_mem_wdata;
  logic        next_skip_taken;
  logic        next_carry_flag;
  logic        next_half_byte_carry_flag;
  logic        next_zero_flag;
  logic        next_signed_range_flag;
  logic        next_signed_result_flag;
  logic        next_chained_zero_flag;

  logic [7:0]  operand;
  logic        borrow_in;
  logic [8:0]  diff;
  logic [4:0]  low_diff;
  logic [7:0]  dec_val;
  logic [7:0]  inc_val;
  logic [7:0]  bit_mask;
  logic        do_sub;
  logic        sub_to_mem;

  // subtract flag results
  logic        sub_carry;
  logic        sub_half;
  logic        sub_zero;
  logic        sub_range;
  logic        sub_sign;
  logic        sub_chain;

  // rotated and swapped bytes
  logic [7:0]  rot_right;
  logic [7:0]  rot_right_carry;
  logic [7:0]  rot_left_carry;
  logic [7:0]  nib_swapped;

  // skip conditions
  logic        skip_dec;
  logic        skip_inc;
  logic        skip_bit;
  logic        skip_byte;

  // ready drops during the dummy cycle so the fetch stalls
  assign op_ready = (state == RSSO_RUN);

  // operand select and adders shared by all subtract forms
  always_comb begin
    operand    = use_imm ? imm_data : mem_data;
    borrow_in  = 1'b0;
    do_sub     = 1'b0;
    sub_to_mem = 1'b0;
    case (op_code)
      RSSO_BORROW_SUBTRACT: begin
        do_sub    = 1'b1;
        borrow_in = ~carry_flag;
      end
      RSSO_BORROW_SUBTRACT_TO_MEMORY: begin
        do_sub     = 1'b1;
        sub_to_mem = 1'b1;
        borrow_in  = ~carry_flag;
      end
      RSSO_MINUS: begin
        do_sub = 1'b1;
      end
      RSSO_MINUS_TO_MEMORY: begin
        do_sub     = 1'b1;
        sub_to_mem = 1'b1;
      end
      default: begin
        do_sub = 1'b0;
      end
    endcase
    // memory forms always take the memory byte, never the immediate
    if (sub_to_mem) begin
      operand = mem_data;
    end
    diff = {1'b0, work_reg} - {1'b0, operand} - {8'h00, borrow_in};
    low_diff = {1'b0, work_reg[3:0]} - {1'b0, operand[3:0]}
               - {4'h0, borrow_in};
    dec_val  = mem_data - ONE_BYTE;
    inc_val  = mem_data + ONE_BYTE;
  end

  // one decoder slice per bit of the selected-bit mask
  for (genvar b = 0; b < DATA_W; b++) begin : g_mask
    assign bit_mask[b] = (bit_sel == 3'(b));
  end

  // flags and bytes computed ahead so the decode stays a plain mux
  always_comb begin
    sub_carry = ~diff[8];
    sub_half  = ~low_diff[NIB];
    sub_zero  = (diff[7:0] == ZERO_BYTE);
    sub_range = (work_reg[MSB] ^ operand[MSB])
                & (work_reg[MSB] ^ diff[MSB]);
    sub_sign  = diff[MSB] ^ sub_range;
    // chained zero also needs the chain's low part zero (zero_flag) only in the borrow forms when no borrow comes in; otherwise it is sub_zero alone
    sub_chain = sub_zero;
    if (!borrow_in && (op_code == RSSO_BORROW_SUBTRACT
                       || op_code == RSSO_BORROW_SUBTRACT_TO_MEMORY)) begin
      sub_chain = sub_zero & zero_flag;
    end
    rot_right       = {mem_data[0], mem_data[MSB:1]};
    rot_right_carry = {carry_flag, mem_data[MSB:1]};
    rot_left_carry  = {mem_data[MSB-1:0], carry_flag};
    nib_swapped     = {mem_data[NIB-1:0], mem_data[MSB:NIB]};
    skip_dec        = (dec_val == ZERO_BYTE);
    skip_inc        = (inc_val == ZERO_BYTE);
    skip_bit        = |(mem_data & bit_mask);
    skip_byte       = (mem_data != ZERO_BYTE);
  end

  always_comb begin
    next_state                = RSSO_RUN;
    next_work_reg             = work_reg;
    next_mem_we               = 1'b0;
    next_mem_wdata            = mem_wdata;
    next_skip_taken           = 1'b0;
    next_carry_flag           = carry_flag;
    next_half_byte_carry_flag = half_byte_carry_flag;
    next_zero_flag            = zero_flag;
    next_signed_range_flag    = signed_range_flag;
    next_signed_result_flag   = signed_result_flag;
    next_chained_zero_flag    = chained_zero_flag;
    if (state == RSSO_DUMMY) begin
      next_state = RSSO_RUN;
    end else if (op_valid) begin
      case (op_code)
        RSSO_ROTATE_LEFT_THRU_CARRY_TO_WORK: begin
          next_work_reg   = rot_left_carry;
          next_carry_flag = mem_data[MSB];
        end
        RSSO_ROTATE_RIGHT: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = rot_right;
        end
        RSSO_ROTATE_RIGHT_TO_WORK: begin
          next_work_reg = rot_right;
        end
        RSSO_ROTATE_RIGHT_THRU_CARRY: begin
          next_mem_we     = 1'b1;
          next_mem_wdata  = rot_right_carry;
          next_carry_flag = mem_data[0];
        end
        RSSO_ROTATE_RIGHT_THRU_CARRY_TO_WORK: begin
          next_work_reg   = rot_right_carry;
          next_carry_flag = mem_data[0];
        end
        RSSO_BORROW_SUBTRACT, RSSO_BORROW_SUBTRACT_TO_MEMORY,
        RSSO_MINUS, RSSO_MINUS_TO_MEMORY: begin
          if (sub_to_mem) begin
            next_mem_we    = 1'b1;
            next_mem_wdata = diff[7:0];
          end else begin
            next_work_reg = diff[7:0];
          end
          next_carry_flag           = sub_carry;
          next_half_byte_carry_flag = sub_half;
          next_zero_flag            = sub_zero;
          next_signed_range_flag    = sub_range;
          next_signed_result_flag   = sub_sign;
          next_chained_zero_flag    = sub_chain;
        end
        RSSO_DECREMENT_SKIP_ZERO: begin
          next_mem_we     = 1'b1;
          next_mem_wdata  = dec_val;
          next_skip_taken = skip_dec;
        end
        RSSO_DECREMENT_TO_WORK_SKIP_ZERO: begin
          next_work_reg   = dec_val;
          next_skip_taken = skip_dec;
        end
        RSSO_INCREMENT_SKIP_ZERO: begin
          next_mem_we     = 1'b1;
          next_mem_wdata  = inc_val;
          next_skip_taken = skip_inc;
        end
        RSSO_INCREMENT_TO_WORK_SKIP_ZERO: begin
          next_work_reg   = inc_val;
          next_skip_taken = skip_inc;
        end
        RSSO_SKIP_NONZERO_BIT: begin
          next_skip_taken = skip_bit;
        end
        RSSO_SKIP_NONZERO: begin
          next_mem_we     = 1'b1;
          next_mem_wdata  = mem_data;
          next_skip_taken = skip_byte;
        end
        RSSO_SET_BYTE: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = ALL_ONES;
        end
        RSSO_SET_BIT: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = mem_data | bit_mask;
        end
        RSSO_NIBBLE_EXCHANGE: begin
          next_mem_we    = 1'b1;
          next_mem_wdata = nib_swapped;
        end
        RSSO_NIBBLE_EXCHANGE_TO_WORK: begin
          next_work_reg = nib_swapped;
        end
        default: begin
          next_state = RSSO_RUN;
        end
      endcase
      // skipping costs one extra dummy cycle for the refetch
      if (next_skip_taken) begin
        next_state = RSSO_DUMMY;
      end
    end
  end

  // state register kept apart from the datapath registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= RSSO_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      work_reg             <= ZERO_BYTE;
      mem_we               <= 1'b0;
      mem_wdata            <= ZERO_BYTE;
      skip_taken           <= 1'b0;
      carry_flag           <= 1'b0;
      half_byte_carry_flag <= 1'b0;
      zero_flag            <= 1'b0;
      signed_range_flag    <= 1'b0;
      signed_result_flag   <= 1'b0;
      chained_zero_flag    <= 1'b0;
    end else begin
      // write and skip strobes last a single cycle
      work_reg             <= next_work_reg;
      mem_we               <= next_mem_we;
      mem_wdata            <= next_mem_wdata;
      skip_taken           <= next_skip_taken;
      carry_flag           <= next_carry_flag;
      half_byte_carry_flag <= next_half_byte_carry_flag;
      zero_flag            <= next_zero_flag;
      signed_range_flag    <= next_signed_range_flag;
      signed_result_flag   <= next_signed_result_flag;
      chained_zero_flag    <= next_chained_zero_flag;
    end
  end

  assign dummy_cycle = (state == RSSO_DUMMY);
endmodule : rsso_unit

// *** rsso_pkg.sv ***
// package with opcodes and constants for the rotate/subtract/skip unit
package rsso_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam int MSB = 7;
  localparam int NIB = 4;
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [4:0] {
    RSSO_NOP,
    RSSO_ROTATE_LEFT_THRU_CARRY_TO_WORK,
    RSSO_ROTATE_RIGHT,
    RSSO_ROTATE_RIGHT_TO_WORK,
    RSSO_ROTATE_RIGHT_THRU_CARRY,
    RSSO_ROTATE_RIGHT_THRU_CARRY_TO_WORK,
    RSSO_BORROW_SUBTRACT,
    RSSO_BORROW_SUBTRACT_TO_MEMORY,
    RSSO_MINUS,
    RSSO_MINUS_TO_MEMORY,
    RSSO_DECREMENT_SKIP_ZERO,
    RSSO_DECREMENT_TO_WORK_SKIP_ZERO,
    RSSO_INCREMENT_SKIP_ZERO,
    RSSO_INCREMENT_TO_WORK_SKIP_ZERO,
    RSSO_SKIP_NONZERO_BIT,
    RSSO_SKIP_NONZERO,
    RSSO_SET_BYTE,
    RSSO_SET_BIT,
    RSSO_NIBBLE_EXCHANGE,
    RSSO_NIBBLE_EXCHANGE_TO_WORK
  } rsso_op_t;

  typedef enum logic {
    RSSO_RUN,
    RSSO_DUMMY
  } rsso_state_t;
endpackage : rsso_pkg

// *** rsso_unit_properties.sv ***
// concurrent checks on the rotate/subtract/skip unit ports
`timescale 1ns/1ps
module rsso_unit_properties (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               op_valid,
  input wire rsso_pkg::rsso_op_t op_code,
  input wire logic [7:0]         mem_data,
  input wire logic               op_ready,
  input wire logic [7:0]         work_reg,
  input wire logic               mem_we,
  input wire logic [7:0]         mem_wdata,
  input wire logic               skip_taken,
  input wire logic               dummy_cycle,
  input wire logic               carry_flag
);
  import rsso_pkg::*;
  logic [7:0] pm;
  logic       tk;
  // operand copy lines up with results one cycle later
  always_ff @(posedge core_clk) pm <= mem_data;
  assign tk = op_valid && op_ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_RLC_WORK: assert property (tk && op_code == RSSO_ROTATE_LEFT_THRU_CARRY_TO_WORK |=> work_reg == {pm[6:0], $past(carry_flag)} && carry_flag == pm[MSB] && !mem_we) else $error("left rotate via carry wrong");
  AST_ROT_R: assert property (tk && op_code == RSSO_ROTATE_RIGHT |=> mem_we && mem_wdata == {pm[0], pm[7:1]} && $stable(carry_flag)) else $error("right rotate wrong");
  AST_ROT_RC: assert property (tk && op_code == RSSO_ROTATE_RIGHT_THRU_CARRY |=> mem_wdata == {$past(carry_flag), pm[7:1]} && carry_flag == pm[0]) else $error("right rotate via carry wrong");
  AST_DEC_SKIP: assert property (tk && op_code == RSSO_DECREMENT_SKIP_ZERO |=> mem_we && mem_wdata == pm - ONE_BYTE && skip_taken == (pm == ONE_BYTE)) else $error("decrement skip wrong");
  AST_SKIP_HOLE: assert property (skip_taken |-> dummy_cycle && !op_ready ##1 op_ready && !skip_taken) else $error("skip without one dummy cycle");
  AST_SET_BYTE: assert property (tk && op_code == RSSO_SET_BYTE |=> mem_we && mem_wdata == ALL_ONES && $stable(carry_flag)) else $error("set byte wrong");
  AST_BYTE_TEST: assert property (tk && op_code == RSSO_SKIP_NONZERO |=> mem_we && mem_wdata == pm && skip_taken == (pm != ZERO_BYTE)) else $error("byte test wrong");
  AST_SWAP_WORK: assert property (tk && op_code == RSSO_NIBBLE_EXCHANGE_TO_WORK |=> work_reg == {pm[NIB-1:0], pm[MSB:NIB]} && !mem_we) else $error("swap to work wrong");
endmodule : rsso_unit_properties

// *** rsso_unit_tb.sv ***
// self-checking random testbench for the rotate/subtract/skip unit
`timescale 1ns/1ps
module rsso_unit_tb;
  import rsso_pkg::*;
  logic        core_clk = 0;
  logic        reset = 1;
  logic        op_valid = 0;
  rsso_op_t    op_code = RSSO_NOP;
  logic [7:0]  mem_data = 8'h00;
  logic [7:0]  imm_data = 8'h00;
  logic        use_imm = 0;
  logic [2:0]  bit_sel = 3'h0;
  logic        op_ready, mem_we, skip_taken, dummy_cycle;
  logic [7:0]  work_reg, mem_wdata, w, wd, m, x, r;
  logic [5:0]  fl, f;
  logic        we, sk, rdy, bi, bo;
  logic [4:0]  lo;
  logic [31:0] rv;
  logic [25:0] q[$];
  logic [25:0] e;
  int          err_count = 0;
  int          n_compared = 0;
  int          seed = 29825;
  rsso_unit i_dut (.core_clk(core_clk), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .mem_data(mem_data), .imm_data(imm_data),
    .use_imm(use_imm), .bit_sel(bit_sel), .op_ready(op_ready),
    .work_reg(work_reg), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
    .carry_flag(fl[5]), .half_byte_carry_flag(fl[4]), .zero_flag(fl[3]),
    .signed_range_flag(fl[2]), .signed_result_flag(fl[1]),
    .chained_zero_flag(fl[0]));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic check(input logic [17:0] s, input logic [17:0] ex);
    n_compared++;
    if (s !== ex) begin
      err_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, s, ex);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // reference model, one step per edge; refused ops leave no trace
  always @(posedge core_clk) begin
    we = 0;
    sk = 0;
    if (reset) begin
      {w, wd, f} = '0;
      rdy = 1;
    end else if (!rdy) rdy = 1;
    else if (op_valid) begin
      m = mem_data;
      bo = op_code inside {RSSO_BORROW_SUBTRACT, RSSO_BORROW_SUBTRACT_TO_MEMORY};
      x = (use_imm && op_code inside {RSSO_BORROW_SUBTRACT, RSSO_MINUS}) ? imm_data : m;
      bi = bo && !f[5];
      case (op_code)
        RSSO_ROTATE_LEFT_THRU_CARRY_TO_WORK: {f[5], w} = {m, f[5]};
        RSSO_ROTATE_RIGHT: {we, wd} = {1'b1, m[0], m[7:1]};
        RSSO_ROTATE_RIGHT_TO_WORK: w = {m[0], m[7:1]};
        RSSO_ROTATE_RIGHT_THRU_CARRY: {we, wd, f[5]} = {1'b1, f[5], m};
        RSSO_ROTATE_RIGHT_THRU_CARRY_TO_WORK: {w, f[5]} = {f[5], m};
        RSSO_DECREMENT_SKIP_ZERO: {we, wd, sk} = {1'b1, m - 8'h01, m == 8'h01};
        RSSO_DECREMENT_TO_WORK_SKIP_ZERO: {w, sk} = {m - 8'h01, m == 8'h01};
        RSSO_INCREMENT_SKIP_ZERO: {we, wd, sk} = {1'b1, m + 8'h01, m == 8'hff};
        RSSO_INCREMENT_TO_WORK_SKIP_ZERO: {w, sk} = {m + 8'h01, m == 8'hff};
        RSSO_SKIP_NONZERO_BIT: sk = m[bit_sel];
        RSSO_SKIP_NONZERO: {we, wd, sk} = {1'b1, m, m != 8'h00};
        RSSO_SET_BYTE: {we, wd} = {1'b1, 8'hff};
        RSSO_SET_BIT: {we, wd} = {1'b1, m | (8'h01 << bit_sel)};
        RSSO_NIBBLE_EXCHANGE: {we, wd} = {1'b1, m[3:0], m[7:4]};
        RSSO_NIBBLE_EXCHANGE_TO_WORK: w = {m[3:0], m[7:4]};
        RSSO_BORROW_SUBTRACT, RSSO_BORROW_SUBTRACT_TO_MEMORY, RSSO_MINUS,
        RSSO_MINUS_TO_MEMORY: begin
          {f[5], r} = {1'b1, w} - {1'b0, x} - bi;
          lo = {1'b1, w[3:0]} - {1'b0, x[3:0]} - bi;
          f[4] = lo[4];
          f[2] = (w[7] ^ x[7]) & (w[7] ^ r[7]);
          f[1] = r[7] ^ f[2];
          f[0] = (r == 8'h00) & (bi | !bo | f[3]);
          f[3] = r == 8'h00;
          if (op_code inside {RSSO_BORROW_SUBTRACT, RSSO_MINUS}) w = r;
          else {we, wd} = {1'b1, r};
        end
        default: ;
      endcase
      rdy = !sk;
    end
    q.push_back({w, we, wd, sk, f, rdy, !rdy});
  end
  always @(negedge core_clk) begin
    if (q.size() != 0) begin
      e = q.pop_front();
      check({work_reg, mem_we, mem_wdata, skip_taken}, e[25:8]);
      check({fl, op_ready, dummy_cycle}, e[7:0]);
    end
  end
  // two reset phases, the second one cutting into random traffic
  initial begin
    for (int p = 0; p < 2; p++) begin
      reset = 1;
      repeat (5) @(negedge core_clk);
      reset = 0;
      repeat (900) begin
        @(negedge core_clk);
        rv = $random(seed);
        op_valid = rv[1:0] != 2'h0;
        {use_imm, bit_sel} = rv[5:2];
        // corner bytes often, so zero results and skips show up
        mem_data = rv[6] ? ({8{rv[7]}} ^ {7'h00, rv[8]}) : rv[23:16];
        imm_data = rv[31:24];
        op_code = rsso_op_t'(5'($unsigned($random(seed)) % 22));
      end
    end
    complete_run();
  end
  initial begin
    #(4000 * 25);
    err_count++;
    complete_run();
  end
endmodule : rsso_unit_tb
bind rsso_unit rsso_unit_properties i_chk (.core_clk(core_clk),
  .reset(reset), .op_valid(op_valid), .op_code(op_code),
  .mem_data(mem_data), .op_ready(op_ready), .work_reg(work_reg),
  .mem_we(mem_we), .mem_wdata(mem_wdata), .skip_taken(skip_taken),
  .dummy_cycle(dummy_cycle), .carry_flag(carry_flag));
